// ===== inc/ctt_pkg.sv
`default_nettype none
package ctt_pkg;
	// Counter geometry; comparator P sees the top three counter bits.
	localparam int CNT_W = 10;
	localparam int P_SHIFT = 7;

	// Register byte addresses on the Avalon slave, one word each.
	localparam logic [4:0] ADDR_CTL0 = 5'h00;
	localparam logic [4:0] ADDR_CTL1 = 5'h04;
	localparam logic [4:0] ADDR_CNTL = 5'h08;
	localparam logic [4:0] ADDR_CNTH = 5'h0c;
	localparam logic [4:0] ADDR_CMPAL = 5'h10;
	localparam logic [4:0] ADDR_CMPAH = 5'h14;

	// Reset values of the control registers.
	localparam logic [7:0] CTL0_RST = 8'h00;
	localparam logic [7:0] CTL1_RST = 8'h00;

	// Operating modes; 2'h1 is undefined and treated like timer mode.
	localparam logic [1:0] MODE_CMP = 2'h0;
	localparam logic [1:0] MODE_PWM = 2'h2;
	localparam logic [1:0] MODE_TMR = 2'h3;

	// Pin function codes, compare mode.
	localparam logic [1:0] PF_NONE = 2'h0;
	localparam logic [1:0] PF_LOW = 2'h1;
	localparam logic [1:0] PF_HIGH = 2'h2;
	localparam logic [1:0] PF_TOGGLE = 2'h3;
	// Pin function codes, PWM mode.
	localparam logic [1:0] PF_INACT = 2'h0;
	localparam logic [1:0] PF_ACT = 2'h1;
	localparam logic [1:0] PF_PWM = 2'h2;

	// Counter clock sources.
	localparam logic [2:0] CK_SYS4 = 3'h0;
	localparam logic [2:0] CK_SYS = 3'h1;
	localparam logic [2:0] CK_HI16 = 3'h2;
	localparam logic [2:0] CK_HI64 = 3'h3;
	localparam logic [2:0] CK_SUB0 = 3'h4;
	localparam logic [2:0] CK_SUB1 = 3'h5;
	localparam logic [2:0] CK_EXTR = 3'h6;
	localparam logic [2:0] CK_EXTF = 3'h7;

	// Default sub clock divider from the system clock.
	localparam int SUB_DIV_DEF = 3814;

	typedef struct packed {
		logic pause_ctrl;
		logic [2:0] count_clock_select;
		logic module_enable;
		logic [2:0] period_compare_value;
	} ctt_ctl0_t;

	typedef struct packed {
		logic [1:0] op_mode_select;
		logic [1:0] pin_function_select;
		logic output_initial_level;
		logic output_invert;
		logic period_duty_swap;
		logic clear_source_select;
	} ctt_ctl1_t;
endpackage
`default_nettype wire

// ===== src/ctt_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none
module ctt_pin_sync
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic pin,
	output logic rise,
	output logic fall
);
	logic s1;
	logic s2;
	logic s3;
	logic level;

	// Three stages; a change is accepted once the second and third agree.
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			s1 <= 1'b0;
			s2 <= 1'b0;
			s3 <= 1'b0;
		end
		else
		begin
			s1 <= pin;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Accepted level and one-cycle edge pulses.
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			level <= 1'b0;
			rise <= 1'b0;
			fall <= 1'b0;
		end
		else
		begin
			rise <= (s2 == s3) && s3 && !level;
			fall <= (s2 == s3) && !s3 && level;
			if (s2 == s3)
				level <= s3;
		end
	end
endmodule
`default_nettype wire

// ===== src/ctt_prescale.sv
`timescale 1ns/100ps
`default_nettype none
module ctt_prescale
#(
	parameter int SUB_DIV = ctt_pkg::SUB_DIV_DEF
)
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic [2:0] sel,
	input wire logic ext_rise,
	input wire logic ext_fall,
	output logic tick
);
	logic [5:0] div;
	logic [11:0] sub_cnt;
	logic sub_tick;

	// Free running divider; the high clock is the system clock here.
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			div <= 6'h00;
		else
			div <= div + 6'h01;
	end

	// Sub clock enable, one pulse every SUB_DIV cycles.
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			sub_cnt <= 12'h000;
			sub_tick <= 1'b0;
		end
		else
		begin
			sub_tick <= (sub_cnt == 12'(SUB_DIV - 1));
			sub_cnt <= (sub_cnt == 12'(SUB_DIV - 1)) ? 12'h000 : sub_cnt + 12'h001;
		end
	end

	// Counter clock selection, one enable pulse per counter clock.
	always_comb
	begin
		case (sel)
			ctt_pkg::CK_SYS4: tick = (div[1:0] == 2'h3);
			ctt_pkg::CK_SYS: tick = 1'b1;
			ctt_pkg::CK_HI16: tick = (div[3:0] == 4'hf);
			ctt_pkg::CK_HI64: tick = (div == 6'h3f);
			ctt_pkg::CK_SUB0, ctt_pkg::CK_SUB1: tick = sub_tick;
			ctt_pkg::CK_EXTR: tick = ext_rise;
			ctt_pkg::CK_EXTF: tick = ext_fall;
			default: tick = 1'b0;
		endcase
	end
endmodule
`default_nettype wire

// ===== src/ctt_timer.sv
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// RQ1 - Ten-bit up-counter advances when enabled, unpaused
// RQ2 - P compares top three bits; A all ten
// RQ3 - Software clears only by enable rise; hardware too
// RQ4 - Pause holds count; release resumes from it
// RQ5 - Clock select picks divided, sub or pin edge
// RQ6 - Enable rise zeroes count; fall holds count
// RQ7 - Enable rise restores initial output level
// RQ8 - Period value n means n times 128 clocks
// RQ9 - P match clears; zero period clears at overflow
// RQ10 - Mode field: compare, PWM, timer; 01 undefined
// RQ11 - Software disables before changing mode
// RQ12 - A match drives none, low, high, toggle
// RQ13 - PWM pin: inactive, active, waveform; 11 undefined
// RQ14 - Software changes pin function only when off
// RQ15 - Output control: initial or active level
// RQ16 - Match to same level leaves pin unchanged
// RQ17 - Invert bit inverts primary pin outside timer mode
// RQ18 - Swap bit exchanges period and duty comparators
// RQ19 - Clear source: A match or P/overflow
// RQ20 - Complementary pin is always primary inverted
// RQ21 - Count read-only pair; compare A read/write pair
// RQ22 - Low byte goes through buffer, high moves it
// RQ23 - Clear by A suppresses P flag; A zero no flag; code still raises P flag when PWM swap bit clears by A
// RQ24 - Match pulses one cycle at first equality
module ctt_timer
#(
	parameter int SUB_DIV = ctt_pkg::SUB_DIV_DEF
)
(
	input wire logic clock,
	input wire logic nrst,
	input wire logic [4:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic ext_count_input,
	output logic timer_out,
	output logic timer_out_inverse,
	output logic match_a_flag,
	output logic match_p_flag
);
	ctt_pkg::ctt_ctl0_t ctl0;
	ctt_pkg::ctt_ctl1_t ctl1;
	logic [9:0] count;
	logic [9:0] compare_a_value;
	logic [7:0] cnt_buf;
	logic [7:0] cmpa_buf;
	logic en_q;
	logic out_lvl;
	logic ext_rise;
	logic ext_fall;
	logic tick;
	logic wr;
	logic rd_take;
	logic en_rise;
	logic run;
	logic [10:0] inc;
	logic a_hit;
	logic p_hit;
	logic clear;
	logic pwm_lvl;
	logic next_out;
	logic [7:0] rd_byte;

	// Span of comparator P in counter clocks; zero stands for a full wrap.
	function automatic logic [10:0] ctt_p_span(input logic [2:0] pv);
		logic [10:0] span;
		span = 11'h400;
		if (pv != 3'h0)
			span = {1'b0, pv, 7'h00};
		return span;
	endfunction

	// External count pin is synchronised before any edge is taken from it.
	ctt_pin_sync u_sync
	(
		.clock(clock),
		.nrst(nrst),
		.pin(ext_count_input),
		.rise(ext_rise),
		.fall(ext_fall)
	);

	// Counter clock enable from the selected source.
	ctt_prescale #(.SUB_DIV(SUB_DIV)) u_pre
	(
		.clock(clock),
		.nrst(nrst),
		.sel(ctl0.count_clock_select), // RQ5
		.ext_rise(ext_rise),
		.ext_fall(ext_fall),
		.tick(tick)
	);

	// A request is answered after exactly one wait cycle.
	assign wr = avs_write && !avs_waitrequest && avs_byteenable[0];
	assign rd_take = avs_read && avs_waitrequest;

	// Waitrequest drops for one cycle after a request is seen.
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			avs_waitrequest <= 1'b1;
		else
			avs_waitrequest <= !(avs_waitrequest && (avs_read || avs_write));
	end

	// Read data multiplexer; unmapped addresses read as zero.
	always_comb
	begin
		case (avs_address)
			ctt_pkg::ADDR_CTL0: rd_byte = ctl0;
			ctt_pkg::ADDR_CTL1: rd_byte = ctl1;
			ctt_pkg::ADDR_CNTL: rd_byte = cnt_buf; // RQ22
			ctt_pkg::ADDR_CNTH: rd_byte = {6'h00, count[9:8]}; // RQ21
			ctt_pkg::ADDR_CMPAL: rd_byte = cmpa_buf; // RQ22
			ctt_pkg::ADDR_CMPAH: rd_byte = {6'h00, compare_a_value[9:8]}; // RQ21
			default: rd_byte = 8'h00;
		endcase
	end

	// Read data are captured when the request is first seen and then held.
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			avs_readdata <= 32'h0000_0000;
		else if (rd_take)
			avs_readdata <= {24'h00_0000, rd_byte};
	end

	// Control registers; the mode must only change while the timer is off.
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			ctl0 <= ctt_pkg::CTL0_RST;
			ctl1 <= ctt_pkg::CTL1_RST;
		end
		else if (wr)
		begin
			if (avs_address == ctt_pkg::ADDR_CTL0)
				ctl0 <= avs_writedata[7:0];
			if (avs_address == ctt_pkg::ADDR_CTL1)
				ctl1 <= avs_writedata[7:0]; // RQ11
		end
	end

	// Compare A pair: low byte waits in the buffer until the high byte lands.
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			compare_a_value <= 10'h000;
			cmpa_buf <= 8'h00;
		end
		else if (wr && avs_address == ctt_pkg::ADDR_CMPAL)
			cmpa_buf <= avs_writedata[7:0]; // RQ22
		else if (wr && avs_address == ctt_pkg::ADDR_CMPAH)
			compare_a_value <= {avs_writedata[1:0], cmpa_buf}; // RQ22
		else if (rd_take && avs_address == ctt_pkg::ADDR_CMPAH)
			cmpa_buf <= compare_a_value[7:0]; // RQ22
	end

	// Reading the count high byte freezes the low byte for the next read.
	// This keeps a two-byte read coherent while the counter keeps running.
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			cnt_buf <= 8'h00;
		else if (rd_take && avs_address == ctt_pkg::ADDR_CNTH)
			cnt_buf <= count[7:0]; // RQ22
	end

	// Enable edge detection.
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			en_q <= 1'b0;
		else
			en_q <= ctl0.module_enable;
	end

	assign en_rise = ctl0.module_enable && !en_q;
	assign run = ctl0.module_enable && !ctl0.pause_ctrl && tick; // RQ1 RQ4
	assign inc = {1'b0, count} + 11'h001;

	// Matches are taken on the value the counter is about to reach.
	assign a_hit = (inc == {1'b0, compare_a_value}) && (compare_a_value != 10'h000); // RQ2 RQ23 RQ24
	assign p_hit = (inc == ctt_p_span(ctl0.period_compare_value)); // RQ2 RQ8 RQ9

	// Clear source: PWM follows the swap bit, other modes the clear bit.
	always_comb
	begin
		if (ctl1.op_mode_select == ctt_pkg::MODE_PWM)
			clear = ctl1.period_duty_swap ? a_hit : p_hit; // RQ18
		else
			clear = ctl1.clear_source_select ? a_hit : p_hit; // RQ19
	end

	// Counter; a wrap past the top value is the overflow clear.
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			count <= 10'h000;
		else if (en_rise)
			count <= 10'h000; // RQ3 RQ6
		else if (run && clear)
			count <= 10'h000; // RQ3 RQ9 RQ19
		else if (run)
			count <= inc[9:0]; // RQ1
	end

	// One-cycle match events toward the interrupt logic outside.
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			match_a_flag <= 1'b0;
			match_p_flag <= 1'b0;
		end
		else
		begin
			match_a_flag <= run && !en_rise && a_hit; // RQ24
			match_p_flag <= run && !en_rise && p_hit && !(ctl1.op_mode_select != ctt_pkg::MODE_PWM
				&& ctl1.clear_source_select); // RQ23
		end
	end

	// Compare mode pin state; driving the level it already has changes nothing.
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			out_lvl <= 1'b0;
		else if (en_rise)
			out_lvl <= ctl1.output_initial_level; // RQ7 RQ15
		else if (run && a_hit && ctl1.op_mode_select == ctt_pkg::MODE_CMP)
		begin
			case (ctl1.pin_function_select) // RQ12 RQ16
				ctt_pkg::PF_LOW: out_lvl <= 1'b0;
				ctt_pkg::PF_HIGH: out_lvl <= 1'b1;
				ctt_pkg::PF_TOGGLE: out_lvl <= !out_lvl;
				default: out_lvl <= out_lvl;
			endcase
		end
	end

	// Edge-aligned PWM: active while the count is below the duty point.
	// A duty at or above the period gives a fully active waveform.
	always_comb
	begin
		if (ctl1.period_duty_swap)
			pwm_lvl = ({1'b0, count} < ctt_p_span(ctl0.period_compare_value)); // RQ18
		else
			pwm_lvl = ({1'b0, count} < {1'b0, compare_a_value}); // RQ18
		if (!ctl1.output_initial_level)
			pwm_lvl = !pwm_lvl; // RQ15
	end

	// Pin level per mode; timer mode and the undefined code hold the pin.
	always_comb
	begin
		case (ctl1.op_mode_select) // RQ10
			ctt_pkg::MODE_CMP: next_out = out_lvl ^ ctl1.output_invert; // RQ17
			ctt_pkg::MODE_PWM:
			begin
				case (ctl1.pin_function_select) // RQ13
					ctt_pkg::PF_ACT: next_out = ctl1.output_initial_level;
					ctt_pkg::PF_PWM: next_out = pwm_lvl;
					default: next_out = !ctl1.output_initial_level;
				endcase
				next_out = next_out ^ ctl1.output_invert; // RQ17
			end
			default: next_out = timer_out;
		endcase
	end

	// Both pins come from flip-flops so they can never disagree.
	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			timer_out <= 1'b0;
			timer_out_inverse <= 1'b1;
		end
		else
		begin
			timer_out <= next_out;
			timer_out_inverse <= !next_out; // RQ20
		end
	end

	// Checks on the counter, match flag, pin and compare A register behaviour.
	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);

	property p_en_clear;
		(ctl0.module_enable && !en_q) |=> (count == 10'h000);
	endproperty
	a_en_clear: assert property (p_en_clear) else $error("count not zero after enable rise"); // RQ6

	property p_pause_hold;
		(en_q && ctl0.module_enable && ctl0.pause_ctrl) |=> $stable(count);
	endproperty
	a_pause_hold: assert property (p_pause_hold) else $error("count moved while paused"); // RQ4

	property p_off_hold;
		!ctl0.module_enable |=> $stable(count);
	endproperty
	a_off_hold: assert property (p_off_hold) else $error("count moved while off"); // RQ6

	property p_advance;
		(en_q && run && !clear) |=> (count == $past(count) + 10'h001);
	endproperty
	a_advance: assert property (p_advance) else $error("count did not advance by one"); // RQ1

	property p_p_clear;
		(match_p_flag && $past(ctl1.op_mode_select) == ctt_pkg::MODE_CMP && !$past(ctl1.clear_source_select))
			|-> (count == 10'h000);
	endproperty
	a_p_clear: assert property (p_p_clear) else $error("P match did not clear count"); // RQ9

	property p_no_pflag;
		(ctl1.op_mode_select != ctt_pkg::MODE_PWM && ctl1.clear_source_select) |=> !match_p_flag;
	endproperty
	a_no_pflag: assert property (p_no_pflag) else $error("P flag raised while A clears"); // RQ23

	property p_compl;
		timer_out_inverse == !timer_out;
	endproperty
	a_compl: assert property (p_compl) else $error("complementary pin not inverse"); // RQ20

	property p_pwm_force;
		(ctl1.op_mode_select == ctt_pkg::MODE_PWM && ctl1.pin_function_select == ctt_pkg::PF_INACT
			&& $stable(ctl1)) |-> (timer_out == !(ctl1.output_initial_level ^ ctl1.output_invert));
	endproperty
	a_pwm_force: assert property (p_pwm_force) else $error("forced inactive level wrong"); // RQ13

	property p_toggle;
		(ctl1.op_mode_select == ctt_pkg::MODE_CMP && ctl1.pin_function_select == ctt_pkg::PF_TOGGLE
			&& run && a_hit && !en_rise) |=> (out_lvl != $past(out_lvl));
	endproperty
	a_toggle: assert property (p_toggle) else $error("A match did not toggle pin"); // RQ12

	property p_cmpa_wr;
		(wr && avs_address == ctt_pkg::ADDR_CMPAH)
			|=> (compare_a_value == {$past(avs_writedata[1:0]), $past(cmpa_buf)});
	endproperty
	a_cmpa_wr: assert property (p_cmpa_wr) else $error("compare A high write lost buffer"); // RQ22
endmodule
`default_nettype wire

// ===== verification/ctt_tb.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic [4:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hf;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic ext_count_input = 1'b0;
	logic timer_out;
	logic timer_out_inverse;
	logic match_a_flag;
	logic match_p_flag;
	int fails = 0;
	int total_checks = 0;
	int p_seen = 0;
	logic [31:0] rd_data;
	int dv[6] = '{4, 1, 16, 64, 4, 4};
	logic [7:0] c1[5] = '{8'h09, 8'h19, 8'h29, 8'h39, 8'h3d};
	logic pre[5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
	logic post[5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b1};
	logic [7:0] pc0[7] = '{8'h1b, 8'h1b, 8'h1b, 8'h1b, 8'h1b, 8'h19, 8'h1b};
	logic [7:0] pc1[7] = '{8'ha8, 8'ha0, 8'h88, 8'h98, 8'hac, 8'haa, 8'hb8};
	logic pfl[7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
	int pwin[7] = '{384, 384, 384, 384, 384, 300, 384};
	int phi[7] = '{300, 84, 0, 384, 84, 128, 0};

	// A short sub clock divider keeps the slow sources affordable.
	ctt_timer #(.SUB_DIV(4)) u_ctt_timer (.clock(clock), .nrst(nrst), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.ext_count_input(ext_count_input), .timer_out(timer_out), .timer_out_inverse(timer_out_inverse),
		.match_a_flag(match_a_flag), .match_p_flag(match_p_flag));

	// System clock at 125 MHz.
	initial
	begin
		forever #4 clock = ~clock;
	end

	task automatic stop_test;
		begin
			$display("checks %0d mismatches %0d", total_checks, fails);
			if (fails == 0 && total_checks > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		begin
			total_checks++;
			if (seen !== exp)
			begin
				fails++;
				$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
			end
		end
	endtask

	// One Avalon transfer; an idle edge first so no signal is assigned twice in a step.
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
		int k;
		begin
			@(posedge clock);
			avs_address <= a;
			avs_writedata <= {24'h0, d};
			avs_write <= wr;
			avs_read <= ~wr;
			k = 0;
			do
			begin
				@(posedge clock);
				k++;
			end
			while (avs_waitrequest !== 1'b0 && k < 20);
			rd_data = avs_readdata;
			avs_write <= 1'b0;
			avs_read <= 1'b0;
			if (avs_waitrequest !== 1'b0)
			begin
				fails++;
				stop_test();
			end
		end
	endtask

	// Count value through the high-then-low sequence so the pair is coherent.
	task automatic rdcnt(output logic [31:0] v);
		logic [1:0] h;
		begin
			bus(1'b0, ctt_pkg::ADDR_CNTH, 8'h00);
			h = rd_data[1:0];
			bus(1'b0, ctt_pkg::ADDR_CNTL, 8'h00);
			v = {22'h0, h, rd_data[7:0]};
		end
	endtask

	// Edges until the chosen flag pulses; a flag that never comes ends the run.
	task automatic wait_flag(input logic p, output int k);
		begin
			k = 0;
			do
			begin
				@(posedge clock);
				k++;
			end
			while ((p ? match_p_flag : match_a_flag) !== 1'b1 && k < 20000);
			if (k >= 20000)
			begin
				fails++;
				stop_test();
			end
		end
	endtask

	// Disable first so the enable write is always a rising edge.
	task automatic run(input logic [7:0] c0);
		begin
			bus(1'b1, ctt_pkg::ADDR_CTL0, 8'h00);
			bus(1'b1, ctt_pkg::ADDR_CTL0, c0);
		end
	endtask

	// Counts comparator P pulses for the clear-source checks.
	always @(posedge clock)
	begin
		if (match_p_flag === 1'b1)
			p_seen <= p_seen + 1;
	end

	// The complementary pin is compared every cycle away from the edge.
	always @(negedge clock)
	begin
		if (nrst === 1'b1)
			chk({31'h0, timer_out_inverse}, {31'h0, ~timer_out});
	end

	// Main sequence.
	initial
	begin
		int k;
		int h;
		logic [31:0] v;
		logic [31:0] w;
		repeat (6) @(posedge clock);
		nrst <= 1'b1;
		bus(1'b0, ctt_pkg::ADDR_CTL0, 8'h00);
		chk(rd_data, {24'h0, ctt_pkg::CTL0_RST});
		bus(1'b0, ctt_pkg::ADDR_CTL1, 8'h00);
		chk(rd_data, {24'h0, ctt_pkg::CTL1_RST});
		chk({31'h0, timer_out}, 32'h0);
		bus(1'b1, 5'h18, 8'hff);
		bus(1'b0, 5'h18, 8'h00);
		chk(rd_data, 32'h0);
		bus(1'b1, ctt_pkg::ADDR_CTL1, 8'ha5);
		avs_byteenable <= 4'h0;
		bus(1'b1, ctt_pkg::ADDR_CTL1, 8'h11);
		avs_byteenable <= 4'hf;
		bus(1'b0, ctt_pkg::ADDR_CTL1, 8'h00);
		chk(rd_data, 32'ha5);
		$display("registers done");
		// Compare A goes through the shared buffer; a lone low write must not land.
		bus(1'b1, ctt_pkg::ADDR_CMPAL, 8'h5a);
		bus(1'b1, ctt_pkg::ADDR_CMPAH, 8'h03);
		bus(1'b1, ctt_pkg::ADDR_CMPAL, 8'h11);
		bus(1'b0, ctt_pkg::ADDR_CMPAH, 8'h00);
		chk(rd_data, 32'h03);
		bus(1'b0, ctt_pkg::ADDR_CMPAL, 8'h00);
		chk(rd_data, 32'h5a);
		bus(1'b1, ctt_pkg::ADDR_CMPAL, 8'h2c);
		bus(1'b1, ctt_pkg::ADDR_CMPAH, 8'h01);
		$display("compare pair done");
		// External pin, rising then falling edge, five pulses each.
		bus(1'b1, ctt_pkg::ADDR_CTL1, 8'hc0);
		for (int s = 0; s < 2; s++)
		begin
			run(s ? 8'h78 : 8'h68);
			repeat (5)
			begin
				ext_count_input <= 1'b1;
				repeat (8) @(posedge clock);
				ext_count_input <= 1'b0;
				repeat (8) @(posedge clock);
			end
			repeat (8) @(posedge clock);
			rdcnt(v);
			chk(v, 32'h5);
		end
		$display("external clock done");
		// Pause holds, resume continues, enable rise while paused zeroes.
		run(8'h18);
		repeat (20) @(posedge clock);
		bus(1'b1, ctt_pkg::ADDR_CTL0, 8'h98);
		rdcnt(v);
		repeat (10) @(posedge clock);
		rdcnt(w);
		chk(w, v);
		bus(1'b1, ctt_pkg::ADDR_CTL0, 8'h18);
		bus(1'b1, ctt_pkg::ADDR_CTL0, 8'h10);
		rdcnt(w);
		chk({31'h0, w > v}, 32'h1);
		repeat (10) @(posedge clock);
		rdcnt(v);
		chk(v, w);
		bus(1'b1, ctt_pkg::ADDR_CTL0, 8'h98);
		rdcnt(v);
		chk(v, 32'h0);
		$display("pause and enable done");
		// Period match spacing for every divided source and period values.
		// The timer is switched off before the mode field changes.
		bus(1'b1, ctt_pkg::ADDR_CTL0, 8'h00);
		bus(1'b1, ctt_pkg::ADDR_CTL1, 8'h00);
		for (int s = 0; s < 6; s++)
		begin
			run({1'b0, 3'(s), 1'b1, 3'h1});
			wait_flag(1'b1, k);
			wait_flag(1'b1, k);
			chk(32'(k), 32'(dv[s] * 128));
		end
		run(8'h18);
		wait_flag(1'b1, k);
		wait_flag(1'b1, k);
		chk(32'(k), 32'd1024);
		run(8'h1f);
		wait_flag(1'b1, k);
		wait_flag(1'b1, k);
		chk(32'(k), 32'd896);
		$display("clock select done");
		// Compare output actions with A clearing at 300 and P set to 128.
		for (int i = 0; i < 5; i++)
		begin
			bus(1'b1, ctt_pkg::ADDR_CTL0, 8'h00);
			bus(1'b1, ctt_pkg::ADDR_CTL1, c1[i]);
			bus(1'b1, ctt_pkg::ADDR_CTL0, 8'h19);
			h = p_seen;
			repeat (3) @(posedge clock);
			chk({31'h0, timer_out}, {31'h0, pre[i]});
			wait_flag(1'b0, k);
			repeat (2) @(posedge clock);
			chk({31'h0, timer_out}, {31'h0, post[i]});
			wait_flag(1'b0, k);
			chk(32'(k), 32'd298);
			chk(32'(p_seen - h), 32'h0);
		end
		$display("compare output done");
		// PWM pin functions, levels, inversion and swapped roles over one period.
		// The last entry uses the undefined pin code, which gives the inactive level.
		for (int i = 0; i < 7; i++)
		begin
			bus(1'b1, ctt_pkg::ADDR_CTL0, 8'h00);
			bus(1'b1, ctt_pkg::ADDR_CTL1, pc1[i]);
			bus(1'b1, ctt_pkg::ADDR_CTL0, pc0[i]);
			wait_flag(pfl[i], k);
			wait_flag(pfl[i], k);
			h = 0;
			repeat (pwin[i])
			begin
				@(posedge clock);
				if (timer_out === 1'b1)
					h++;
			end
			chk(32'(h), 32'(phi[i]));
		end
		$display("pwm done");
		stop_test();
	end
endmodule
`default_nettype wire
